// ===== design/hgs_pkg.sv
package hgs_pkg;

  // Direction of the bridge.
  typedef enum logic [1:0] {
    HGS_DIR_FWD = 2'h1,
    HGS_DIR_REV = 2'h2
  } hgs_dir_t;

  // Indicator commands carried by link messages and control writes.
  localparam logic [1:0] HGS_IND_OFF = 2'h0;
  localparam logic [1:0] HGS_IND_ON = 2'h1;
  localparam logic [1:0] HGS_IND_BLINK = 2'h2;

  // Released pin enables and idle grant levels.
  localparam logic [3:0] HGS_PINS_RELEASED = 4'hF;
  localparam logic [2:0] HGS_GNT_IDLE = 3'h7;

  // Fixed SMBus address bits 7 down to 5.
  localparam logic [2:0] HGS_SMB_ADDR_HI = 3'h6;
  // Command byte of every word access sequence.
  localparam logic [7:0] HGS_SMB_CMD_WORD = 8'h08;

  // Core clock rate and timing figures.
  localparam int HGS_CLK_HZ = 20000000;
  localparam int HGS_BLINK_HZ = 2;
  localparam int HGS_BLINK_HALF_CYC = HGS_CLK_HZ / (2 * HGS_BLINK_HZ);
  localparam int HGS_DEBOUNCE_MS = 5;
  localparam int HGS_DEBOUNCE_CYC = (HGS_CLK_HZ / 1000) * HGS_DEBOUNCE_MS;

  // Slot status bit positions.
  localparam int HGS_ST_BUTTON = 0;
  localparam int HGS_ST_LATCH_CHG = 1;
  localparam int HGS_ST_PRES_CHG = 2;
  localparam int HGS_ST_CMD_DONE = 3;
  localparam int HGS_ST_LINK_CHG = 4;
  localparam int HGS_ST_LATCH = 5;
  localparam int HGS_ST_PRES = 6;
  localparam int HGS_ST_LINK = 7;
  localparam int HGS_ST_W = 8;

endpackage

// ===== design/hgs_gpio.sv
`timescale 1ns/1ps
`default_nettype none
module hgs_gpio #(
  parameter int DEBOUNCE_CYC = hgs_pkg::HGS_DEBOUNCE_CYC,
  parameter int BLINK_HALF_CYC = hgs_pkg::HGS_BLINK_HALF_CYC
) (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Fundamental reset, active low.
  input wire logic hotplug_strap_select, // Hot-plug strap.
  input wire logic interface_strap_bit0, // Interface strap bit 0.
  input wire logic interface_strap_bit1, // Interface strap bit 1.
  input wire logic reverse_mode, // High for reverse bridge direction.
  input wire logic hotplug_enable, // Hot-plug event enable.
  input wire logic [3:0] gpio_in, // Pin levels.
  output logic [3:0] gpio_out, // Pin drive values.
  output logic [3:0] gpio_oe_n, // Pin output enables, low drives.
  input wire logic ind_msg_valid, // Indicator message received on link.
  input wire logic [1:0] ind_msg_cmd, // Received indicator command.
  input wire logic ind_msg_power, // Message is for power indicator.
  input wire logic button_msg_rx, // Button message received on link.
  input wire logic ctrl_write, // Root complex writes indicator control.
  input wire logic [1:0] ctrl_cmd, // Written indicator command.
  input wire logic ctrl_power, // Write targets power indicator.
  input wire logic cmd_done, // Hot-plug command finished pulse.
  input wire logic link_active, // Link-active flag.
  input wire logic [7:0] status_clear, // Write one to clear change bits.
  output logic button_msg_tx, // Send button message pulse.
  output logic ind_msg_tx, // Send indicator message pulse.
  output logic [1:0] ind_msg_tx_cmd, // Command of sent message.
  output logic ind_msg_tx_power, // Sent message targets power.
  output logic [7:0] slot_status, // Slot status register.
  output logic hotplug_event, // Hot-plug event pulse.
  output logic smb_enable, // SMBus slave enabled.
  output logic [7:0] smb_address, // SMBus slave address byte.
  input wire logic ext_arbiter_sel, // External arbiter selected.
  input wire logic large_package, // Larger package bonding.
  input wire logic [3:1] arb_req_n_in, // Arbiter request pin levels.
  input wire logic [2:0] extra_gpo_value, // Values for extra outputs.
  output logic [3:1] arb_gnt_n_out, // Grant pin drive.
  output logic [2:0] extra_general_input // Extra inputs seen.
);

  logic hp_mode;
  logic fwd_hp;
  logic rev_hp;
  logic btn_stable_reg;
  logic [31:0] deb_cnt_reg;
  logic btn_rise;
  logic [1:0] ind_state_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic [2:0] in_prev_reg;
  logic link_prev_reg;
  logic [7:0] stat_set;
  logic [7:0] stat_next;
  logic btn_req;
  logic edge_arm_reg;

  // One function decides whether a change should raise an event.
  function automatic logic hgs_evt(input logic en, input logic [7:0] s);
    hgs_evt = en && (s != 8'h00);
  endfunction

  // Hot-plug modes; SMBus use of the pins takes precedence over hot-plug.
  // strap gating
  assign hp_mode = hotplug_strap_select && !interface_strap_bit0;
  assign fwd_hp = hp_mode && !reverse_mode;
  assign rev_hp = hp_mode && reverse_mode;

  // Button debounce: a level only counts after staying put long enough.
  // stable count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_stable_reg <= 1'b0;
      deb_cnt_reg <= 32'h0;
    end else if (gpio_in[1] == btn_stable_reg) begin
      deb_cnt_reg <= 32'h0;
    end else if (deb_cnt_reg >= 32'(DEBOUNCE_CYC - 1)) begin
      btn_stable_reg <= gpio_in[1];
      deb_cnt_reg <= 32'h0;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 32'h1;
    end
  end

  assign btn_rise = (gpio_in[1] != btn_stable_reg) && gpio_in[1] &&
                    (deb_cnt_reg >= 32'(DEBOUNCE_CYC - 1));

  // Button message to the link in forward direction.
  // one message per press
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      button_msg_tx <= 1'b0;
    end else begin
      button_msg_tx <= fwd_hp && btn_rise;
    end
  end

  // Indicator state follows link messages forward, control writes reverse.
  // indicator commands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_state_reg <= hgs_pkg::HGS_IND_OFF;
      ind_msg_tx <= 1'b0;
      ind_msg_tx_cmd <= hgs_pkg::HGS_IND_OFF;
      ind_msg_tx_power <= 1'b0;
    end else begin
      ind_msg_tx <= rev_hp && ctrl_write;
      if (rev_hp && ctrl_write) begin
        ind_state_reg <= ctrl_cmd;
        ind_msg_tx_cmd <= ctrl_cmd;
        ind_msg_tx_power <= ctrl_power;
      end else if (fwd_hp && ind_msg_valid) begin
        ind_state_reg <= ind_msg_cmd;
      end
    end
  end

  // Blink divider; a free-running phase keeps the 2Hz rate exact.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_reg <= 32'h0;
      blink_phase_reg <= 1'b0;
    end else if (blink_cnt_reg >= 32'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_reg <= 32'h0;
      blink_phase_reg <= !blink_phase_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // Pin three drive: on high, off low, blink toggles with the divider.
  // Outside hot-plug use the pin floats, which leaves both lamps dark and keeps
  // the line free for the address strap; pins 0..2 are always inputs.
  // tri-level output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_out <= 4'h0;
      gpio_oe_n <= hgs_pkg::HGS_PINS_RELEASED;
    end else begin
      gpio_out[2:0] <= 3'h0;
      gpio_oe_n[2:0] <= hgs_pkg::HGS_PINS_RELEASED[2:0];
      gpio_out[3] <= (ind_state_reg == hgs_pkg::HGS_IND_ON) ||
                     ((ind_state_reg == hgs_pkg::HGS_IND_BLINK) && blink_phase_reg);
      gpio_oe_n[3] <= !hp_mode;
    end
  end

  // Change detection of the sensor inputs and the link flag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_prev_reg <= 3'h0;
      link_prev_reg <= 1'b0;
    end else begin
      in_prev_reg <= {gpio_in[2], gpio_in[1], gpio_in[0]};
      link_prev_reg <= link_active;
    end
  end

  // Change detection is armed one cycle after reset: the first sample only
  // seeds the previous values, so a card already seated at release is not
  // reported as a fresh insertion.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_arm_reg <= 1'b0;
    end else begin
      edge_arm_reg <= 1'b1;
    end
  end

  assign btn_req = button_msg_rx || btn_rise;

  // Sticky change bits; a set in the same cycle as a clear wins.
  // button status
  always_comb begin
    stat_set = 8'h00;
    if (rev_hp) begin
      stat_set[hgs_pkg::HGS_ST_BUTTON] = btn_req;
      stat_set[hgs_pkg::HGS_ST_LATCH_CHG] = edge_arm_reg && (gpio_in[2] != in_prev_reg[2]);
      stat_set[hgs_pkg::HGS_ST_PRES_CHG] = edge_arm_reg && (gpio_in[0] != in_prev_reg[0]);
    end
    if (hp_mode) begin
      stat_set[hgs_pkg::HGS_ST_CMD_DONE] = cmd_done;
      stat_set[hgs_pkg::HGS_ST_LINK_CHG] = edge_arm_reg && (link_active != link_prev_reg);
    end
    stat_next = (slot_status & ~status_clear) | stat_set;
    stat_next[hgs_pkg::HGS_ST_PRES] = gpio_in[0];
    stat_next[hgs_pkg::HGS_ST_LATCH] = gpio_in[2];
    stat_next[hgs_pkg::HGS_ST_LINK] = link_active;
  end

  // Status register and event pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_status <= 8'h00;
      hotplug_event <= 1'b0;
    end else begin
      slot_status <= stat_next;
      hotplug_event <= hgs_evt(hotplug_enable, stat_set);
    end
  end

  // SMBus identity from the pins; the host side of the protocol
  // (command 08h, zero id bytes, word order) is decoded outside this block.
  // pins as address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smb_enable <= 1'b0;
      smb_address <= 8'h00;
    end else begin
      smb_enable <= interface_strap_bit0 && !interface_strap_bit1;
      if (interface_strap_bit0) begin
        smb_address <= {hgs_pkg::HGS_SMB_ADDR_HI, gpio_in, 1'b0};
      end
    end
  end

  // Arbiter pins become extra inputs and outputs; grants idle high otherwise.
  // arbiter remap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_gnt_n_out <= hgs_pkg::HGS_GNT_IDLE;
      extra_general_input <= 3'h0;
    end else if (ext_arbiter_sel && large_package) begin
      arb_gnt_n_out <= extra_gpo_value;
      extra_general_input <= arb_req_n_in;
    end else begin
      arb_gnt_n_out <= hgs_pkg::HGS_GNT_IDLE;
      extra_general_input <= 3'h0;
    end
  end

  // Checks on the strap decode and the SMBus identity.
  a_smb_addr_map: assert property (@(posedge clk) disable iff (!rst_n)
    interface_strap_bit0 |=> smb_address == {hgs_pkg::HGS_SMB_ADDR_HI, $past(gpio_in), 1'b0})
    else $error("SMBus address mismatch");
  a_smb_en_straps: assert property (@(posedge clk) disable iff (!rst_n)
    smb_enable == $past(interface_strap_bit0 && !interface_strap_bit1))
    else $error("SMBus enable wrong");
  a_smb_pins_in: assert property (@(posedge clk) disable iff (!rst_n)
    interface_strap_bit0 |=> gpio_oe_n == hgs_pkg::HGS_PINS_RELEASED)
    else $error("Pins driven while they carry the address strap");
  a_no_hp_fwd_msg: assert property (@(posedge clk) disable iff (!rst_n)
    !hp_mode |=> !button_msg_tx)
    else $error("Hot-plug message outside hot-plug mode");
  a_ind_rev_only: assert property (@(posedge clk) disable iff (!rst_n)
    !rev_hp |=> !ind_msg_tx)
    else $error("Indicator message outside reverse hot-plug use");
  // Checks on the indicator pin.
  a_pin3_off_low: assert property (@(posedge clk) disable iff (!rst_n)
    (hp_mode && ind_state_reg == hgs_pkg::HGS_IND_OFF) |=> !gpio_oe_n[3] && !gpio_out[3])
    else $error("Pin three not low when off");
  a_pin3_float_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !hp_mode |=> gpio_oe_n[3])
    else $error("Pin three driven outside hot-plug use");
  a_pin3_on_high: assert property (@(posedge clk) disable iff (!rst_n)
    (hp_mode && ind_state_reg == hgs_pkg::HGS_IND_ON) |=> !gpio_oe_n[3] && gpio_out[3])
    else $error("Pin three not high when on");
  a_pin3_blink: assert property (@(posedge clk) disable iff (!rst_n)
    (hp_mode && ind_state_reg == hgs_pkg::HGS_IND_BLINK) |=> !gpio_oe_n[3] && gpio_out[3] == $past(blink_phase_reg))
    else $error("Pin three not following the blink phase");
  // Checks on the button path.
  a_btn_msg_fwd: assert property (@(posedge clk) disable iff (!rst_n)
    button_msg_tx |-> ##1 !button_msg_tx)
    else $error("Button message repeated");
  a_btn_level_high: assert property (@(posedge clk) disable iff (!rst_n)
    button_msg_tx |-> $past(gpio_in[1]))
    else $error("Button message without a high button input");
  a_btn_stable_span: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(btn_stable_reg) |-> $past(deb_cnt_reg) == 32'(DEBOUNCE_CYC - 1))
    else $error("Button accepted before its stable span");
  // Checks on the link messages.
  a_ind_msg_rev: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_hp && ctrl_write) |=> ind_msg_tx && ind_msg_tx_cmd == $past(ctrl_cmd))
    else $error("Indicator message missing");
  a_ind_tx_power: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_hp && ctrl_write) |=> ind_msg_tx_power == $past(ctrl_power))
    else $error("Indicator message target wrong");
  // Checks on the slot status and the event pulse.
  a_evt_gated: assert property (@(posedge clk) disable iff (!rst_n)
    hotplug_event |-> $past(hotplug_enable))
    else $error("Event while disabled");
  a_evt_cmd_done: assert property (@(posedge clk) disable iff (!rst_n)
    (hp_mode && hotplug_enable && cmd_done) |=> hotplug_event)
    else $error("No event for command completion");
  a_cmd_done_set: assert property (@(posedge clk) disable iff (!rst_n)
    (hp_mode && cmd_done) |=> slot_status[hgs_pkg::HGS_ST_CMD_DONE])
    else $error("Command done not set");
  a_link_chg_set: assert property (@(posedge clk) disable iff (!rst_n)
    (hp_mode && edge_arm_reg && $changed(link_active)) |=> slot_status[hgs_pkg::HGS_ST_LINK_CHG])
    else $error("Link change not recorded");
  a_btn_rx_set: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_hp && button_msg_rx) |=> slot_status[hgs_pkg::HGS_ST_BUTTON])
    else $error("Button message not recorded");
  a_pres_chg_set: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_hp && edge_arm_reg && $changed(gpio_in[0])) |=> slot_status[hgs_pkg::HGS_ST_PRES_CHG])
    else $error("Presence change not recorded");
  a_latch_chg_set: assert property (@(posedge clk) disable iff (!rst_n)
    (rev_hp && edge_arm_reg && $changed(gpio_in[2])) |=> slot_status[hgs_pkg::HGS_ST_LATCH_CHG])
    else $error("Latch change not recorded");
  a_pres_level: assert property (@(posedge clk) disable iff (!rst_n)
    edge_arm_reg |-> slot_status[hgs_pkg::HGS_ST_PRES] == $past(gpio_in[0]))
    else $error("Presence level not tracked");
  a_latch_level: assert property (@(posedge clk) disable iff (!rst_n)
    edge_arm_reg |-> slot_status[hgs_pkg::HGS_ST_LATCH] == $past(gpio_in[2]))
    else $error("Latch level not tracked");
  // Checks on the arbiter pin remap.
  a_arb_remap: assert property (@(posedge clk) disable iff (!rst_n)
    (ext_arbiter_sel && large_package) |=> (extra_general_input == $past(arb_req_n_in)) &&
      (arb_gnt_n_out == $past(extra_gpo_value)))
    else $error("Arbiter pins not remapped");

endmodule
`default_nettype wire

// ===== tb/hgs_slot_model.sv
`timescale 1ns/1ps
`default_nettype none
module hgs_slot_model (
  input wire logic clk, // Core clock.
  input wire logic strap_mode, // High while the pins are board straps.
  input wire logic [3:0] strap_val, // Strap levels.
  input wire logic card_in, // Card seated.
  input wire logic button_down, // Button held.
  input wire logic latch_closed, // Latch sensor closed.
  input wire logic [3:0] pin_out, // Device drive values.
  input wire logic [3:0] pin_oe_n, // Device enables, low drives.
  output logic [3:0] pin_level, // Resolved pin levels.
  output logic [1:0] led_code // 1 attention on, 2 power off, 0 both off.
);
  logic float_lvl = 1'b0;
  // The indicator line has no pull, so a released line wanders instead of holding.
  always @(posedge clk) begin
    float_lvl <= ~pin_level[3];
  end
  // Sensors in slot use, strap levels otherwise.
  assign pin_level[2:0] = strap_mode ? strap_val[2:0] : {latch_closed, button_down, card_in};
  assign pin_level[3] = strap_mode ? strap_val[3] : (!pin_oe_n[3] ? pin_out[3] : float_lvl);
  assign led_code = (strap_mode || pin_oe_n[3]) ? 2'h0 : (pin_out[3] ? 2'h1 : 2'h2);
endmodule
`default_nettype wire

// ===== tb/tb_hgs_gpio.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hgs_gpio;
  logic clk, rst_n, hotplug_strap_select, interface_strap_bit0, interface_strap_bit1, reverse_mode;
  logic hotplug_enable, ind_msg_valid, ind_msg_power, button_msg_rx, ctrl_write, ctrl_power, cmd_done;
  logic link_active, button_msg_tx, ind_msg_tx, ind_msg_tx_power, hotplug_event, smb_enable, prev;
  logic ext_arbiter_sel, large_package, strap_mode, card, btn, latch;
  logic [1:0] ind_msg_cmd, ctrl_cmd, ind_msg_tx_cmd, led;
  logic [2:0] arb_req_n_in, extra_gpo_value, extra_general_input;
  logic [3:1] arb_gnt_n_out;
  logic [3:0] gpio_in, gpio_out, gpio_oe_n, strap_val;
  logic [7:0] status_clear, slot_status, smb_address;
  int n_errors = 0;
  int compares = 0;
  int n_evt = 0;
  int n_btn = 0;
  int n_ind = 0;
  int e0, b0, i0, tog;
  hgs_gpio #(.DEBOUNCE_CYC(4), .BLINK_HALF_CYC(8)) dut (.clk, .rst_n, .hotplug_strap_select, .interface_strap_bit0,
    .interface_strap_bit1, .reverse_mode, .hotplug_enable, .gpio_in, .gpio_out, .gpio_oe_n, .ind_msg_valid,
    .ind_msg_cmd, .ind_msg_power, .button_msg_rx, .ctrl_write, .ctrl_cmd, .ctrl_power, .cmd_done, .link_active,
    .status_clear, .button_msg_tx, .ind_msg_tx, .ind_msg_tx_cmd, .ind_msg_tx_power, .slot_status, .hotplug_event,
    .smb_enable, .smb_address, .ext_arbiter_sel, .large_package, .arb_req_n_in, .extra_gpo_value, .arb_gnt_n_out,
    .extra_general_input);
  hgs_slot_model slot (.clk, .strap_mode, .strap_val, .card_in(card), .button_down(btn), .latch_closed(latch),
    .pin_out(gpio_out), .pin_oe_n(gpio_oe_n), .pin_level(gpio_in), .led_code(led));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulses are totalled so a scenario can compare counts instead of exact cycles.
  always @(posedge clk) begin
    n_evt += int'(hotplug_event === 1'b1);
    n_btn += int'(button_msg_tx === 1'b1);
    n_ind += int'(ind_msg_tx === 1'b1);
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // zero id bytes
  // Bytes a host sends in a word access: write address, command, zero bus and
  // device ids, then the read address after the repeated start.
  function automatic logic [7:0] host_byte(input int idx, input logic [3:0] straps);
    case (idx)
      0: host_byte = {hgs_pkg::HGS_SMB_ADDR_HI, straps, 1'b0};
      1: host_byte = hgs_pkg::HGS_SMB_CMD_WORD;
      4: host_byte = {hgs_pkg::HGS_SMB_ADDR_HI, straps, 1'b1};
      default: host_byte = 8'h00;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send_ind(input logic [1:0] c, input logic p);
    {ind_msg_valid, ind_msg_cmd, ind_msg_power} = {1'b1, c, p};
    tick(1);
    ind_msg_valid = 1'b0;
    tick(3);
  endtask
  task automatic ctrl_wr(input logic [1:0] c, input logic p);
    {ctrl_write, ctrl_cmd, ctrl_power} = {1'b1, c, p};
    tick(1);
    ctrl_write = 1'b0;
    tick(3);
  endtask
  // Checks status and event count, then clears the sticky bits and checks they went.
  task automatic exp_st(input logic [7:0] st, input int ev);
    chk(slot_status, st);
    chk(8'(n_evt - e0), 8'(ev));
    status_clear = st & 8'h1F;
    tick(1);
    status_clear = 8'h00;
    tick(3);
    chk(slot_status, st & 8'hE0);
    e0 = n_evt;
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the roughly 275 cycles the tests need.
  initial begin
    #(50 * 4000);
    n_errors++;
    final_report();
  end
  initial begin
    {rst_n, hotplug_strap_select, interface_strap_bit0, interface_strap_bit1, reverse_mode, hotplug_enable,
      ind_msg_valid, ind_msg_power, button_msg_rx, ctrl_write, ctrl_power, cmd_done, link_active, ext_arbiter_sel,
      large_package, strap_mode, card, btn, latch, ind_msg_cmd, ctrl_cmd, arb_req_n_in, extra_gpo_value, strap_val,
      status_clear} = '0;
    tick(12);
    chk({4'h0, gpio_oe_n}, 8'h0F);
    chk({5'h0, arb_gnt_n_out}, 8'h07);
    rst_n = 1'b1;
    tick(2);
    // Address straps win over the hot-plug select; every strap value is tried.
    {strap_mode, interface_strap_bit0, hotplug_strap_select} = 3'b111;
    send_ind(hgs_pkg::HGS_IND_ON, 1'b0);
    for (int k = 0; k < 16; k++) begin
      strap_val = 4'(k);
      tick(3);
      chk(smb_address, {hgs_pkg::HGS_SMB_ADDR_HI, 4'(k), 1'b0});
      chk({4'h0, gpio_oe_n}, 8'h0F);
    end
    chk({7'h0, smb_enable}, 8'h01);
    chk(smb_address, host_byte(0, strap_val));
    chk({smb_address[7:1], 1'b1}, host_byte(4, strap_val));
    interface_strap_bit1 = 1'b1;
    tick(3);
    chk({7'h0, smb_enable}, 8'h00);
    // Forward bridge with hot-plug pins.
    {strap_mode, interface_strap_bit0, interface_strap_bit1} = 3'b000;
    tick(3);
    send_ind(hgs_pkg::HGS_IND_ON, 1'b0);
    chk({6'h0, gpio_oe_n[3], gpio_out[3]}, 8'h01);
    chk({6'h0, led}, 8'h01);
    send_ind(hgs_pkg::HGS_IND_OFF, 1'b1);
    chk({6'h0, gpio_oe_n[3], gpio_out[3]}, 8'h00);
    chk({6'h0, led}, 8'h02);
    send_ind(hgs_pkg::HGS_IND_BLINK, 1'b0);
    tog = 0;
    for (int k = 0; k < 32; k++) begin
      prev = gpio_out[3];
      tick(1);
      tog += int'(gpio_out[3] !== prev);
    end
    chk(8'(tog), 8'(32 / 8));
    i0 = n_ind;
    ctrl_wr(hgs_pkg::HGS_IND_ON, 1'b0);
    chk(8'(n_ind - i0), 8'h00);
    b0 = n_btn;
    btn = 1'b1;
    tick(2);
    btn = 1'b0;
    tick(12);
    chk(8'(n_btn - b0), 8'h00);
    btn = 1'b1;
    tick(12);
    btn = 1'b0;
    tick(12);
    chk(8'(n_btn - b0), 8'h01);
    hotplug_strap_select = 1'b0;
    tick(3);
    chk({6'h0, led}, 8'h00);
    // Reverse bridge: each cause sets its status bit, and one event while hotplug_enable is high.
    {hotplug_strap_select, reverse_mode, hotplug_enable} = 3'b111;
    tick(4);
    e0 = n_evt;
    card = 1'b1;
    tick(4);
    exp_st(8'h44, 1);
    latch = 1'b1;
    tick(4);
    exp_st(8'h62, 1);
    button_msg_rx = 1'b1;
    tick(1);
    button_msg_rx = 1'b0;
    tick(3);
    exp_st(8'h61, 1);
    cmd_done = 1'b1;
    tick(1);
    cmd_done = 1'b0;
    tick(3);
    exp_st(8'h68, 1);
    link_active = 1'b1;
    tick(4);
    exp_st(8'hF0, 1);
    btn = 1'b1;
    tick(12);
    btn = 1'b0;
    tick(12);
    exp_st(8'hE1, 1);
    hotplug_enable = 1'b0;
    card = 1'b0;
    tick(4);
    exp_st(8'hA4, 0);
    link_active = 1'b0;
    tick(4);
    exp_st(8'h30, 0);
    // Control writes in the order blink, off, on, alternating the target.
    for (int k = 0; k < 3; k++) begin
      i0 = n_ind;
      ctrl_wr(2'((k + 2) % 3), k[0]);
      chk(8'(n_ind - i0), 8'h01);
      chk({5'h0, ind_msg_tx_power, ind_msg_tx_cmd}, {5'h0, k[0], 2'((k + 2) % 3)});
      chk({6'h0, gpio_oe_n[3], gpio_out[3] & (k != 0)}, 8'(k / 2));
    end
    send_ind(hgs_pkg::HGS_IND_OFF, 1'b0);
    chk({6'h0, gpio_oe_n[3], gpio_out[3]}, 8'h01);
    {ext_arbiter_sel, large_package} = 2'b11;
    for (int k = 1; k < 8; k += 3) begin
      arb_req_n_in = 3'(k);
      extra_gpo_value = 3'(~k);
      tick(3);
      chk({5'h0, extra_general_input}, 8'(k));
      chk({5'h0, arb_gnt_n_out}, {5'h0, 3'(~k)});
    end
    final_report();
  end
endmodule
`default_nettype wire
